// ===== mdma_defs.svh
// offsets, field positions, reset values and fixed levels for the micro dma engine
// assumes an 8-bit cpu register address and a 6-bit interrupt vector number space
`ifndef MDMA_DEFS_SVH
`define MDMA_DEFS_SVH

// register port address map: kind in [7:4], channel in [2:0]
`define MDMA_ADDR_SOFT      8'h00
`define MDMA_ADDR_BURST     8'h01
`define MDMA_KIND_SRC       4'h1
`define MDMA_KIND_DST       4'h2
`define MDMA_KIND_CNT       4'h3
`define MDMA_KIND_MODE      4'h4
`define MDMA_KIND_VEC       4'h5

// mode register fields
`define MDMA_MODE_SIZE_LSB  0
`define MDMA_MODE_SRC_LSB   2
`define MDMA_MODE_DST_LSB   4

// reset values
`define MDMA_SOFT_RST       8'h00
`define MDMA_BURST_RST      8'h00
`define MDMA_VEC_RST        6'h00

// service level and bus reach
`define MDMA_LEVEL          3'h6
`define MDMA_ADDR_BITS      24
`define MDMA_VEC_NONE       6'h00

`endif

// ===== mdma_pkg.sv
// types shared by the micro dma engine files
// assumes nothing beyond the defs header
`default_nettype none
package mdma_pkg;
  typedef enum logic [1:0] {
    MDMA_SIZE_1B,
    MDMA_SIZE_2B,
    MDMA_SIZE_4B,
    MDMA_SIZE_RSV
  } mdma_size_e;
  typedef enum logic [1:0] {
    MDMA_STEP_HOLD,
    MDMA_STEP_INC,
    MDMA_STEP_DEC,
    MDMA_STEP_RSV
  } mdma_step_e;
  typedef enum {
    MDMA_ST_IDLE,
    MDMA_ST_PF1,
    MDMA_ST_PF2,
    MDMA_ST_READ,
    MDMA_ST_WRITE,
    MDMA_ST_PF5
  } mdma_state_e;
endpackage
`default_nettype wire

// ===== mdma_fifo.sv
// data fifo between the read and write halves of a service
// assumes one clock and a synchronous active-high reset
`default_nettype none
module mdma_fifo #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 16
) (
  input  wire logic             sys_clk_i,
  input  wire logic             rst_i,
  input  wire logic             in_valid_i,
  output logic                  in_ready_o,
  input  wire logic [WIDTH-1:0] in_data_i,
  output logic                  out_valid_o,
  input  wire logic             out_ready_i,
  output logic      [WIDTH-1:0] out_data_o
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic [AW-1:0]    wr_ptr_reg;
  logic [AW-1:0]    rd_ptr_reg;
  logic [AW:0]      count_reg;
  wire              push;
  wire              pop;

  assign in_ready_o  = (count_reg != (AW+1)'(DEPTH));
  assign out_valid_o = (count_reg != '0);
  assign out_data_o  = mem_reg[rd_ptr_reg];
  assign push        = in_valid_i && in_ready_o;
  assign pop         = out_valid_o && out_ready_i;

  always_ff @(posedge sys_clk_i) begin
    if (push) begin
      mem_reg[wr_ptr_reg] <= in_data_i;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg  <= '0;
    end else begin
      if (push) begin
        wr_ptr_reg <= (wr_ptr_reg == AW'(DEPTH-1)) ? '0 : wr_ptr_reg + 1'b1;
      end
      if (pop) begin
        rd_ptr_reg <= (rd_ptr_reg == AW'(DEPTH-1)) ? '0 : rd_ptr_reg + 1'b1;
      end
      count_reg <= count_reg + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule
`default_nettype wire

// ===== mdma_prio.sv
// fixed priority picker, lowest index wins
// assumes a request vector that is stable for the cycle
`default_nettype none
module mdma_prio #(
  parameter int N = 8
) (
  input  wire logic [N-1:0]         req_i,
  output logic                      any_o,
  output logic      [$clog2(N)-1:0] idx_o
);
  always_comb begin
    any_o = 1'b0;
    idx_o = '0;
    for (int i = N - 1; i >= 0; i--) begin
      if (req_i[i]) begin
        any_o = 1'b1;
        idx_o = ($clog2(N))'(i);
      end
    end
  end
endmodule
`default_nettype wire

// ===== mdma_top.sv
// eight-channel micro dma engine between interrupt controller and cpu bus
// assumes a memory bus that acknowledges each access with a one-cycle ack
`include "mdma_defs.svh"
`default_nettype none

////////////////////////////////////////////////////////////////////////////////
module mdma_top
  import mdma_pkg::*;
#(
  parameter int CHANNELS   = 8,
  parameter int FIFO_DEPTH = 16
) (
  input  wire logic        sys_clk_i,
  input  wire logic        rst_i,
  // cpu register port, also reached by the control register load
  input  wire logic        reg_wr_i,
  input  wire logic [7:0]  reg_addr_i,
  input  wire logic [31:0] reg_wdata_i,
  output logic      [31:0] reg_rdata_o,
  // interrupt controller side
  input  wire logic [63:0] irq_pend_i,
  input  wire logic [2:0]  cpu_imask_i,
  input  wire logic        cpu_halt_i,
  output logic      [63:0] irq_clr_o,
  output logic      [63:0] src_claimed_o,
  output logic      [7:0]  transfer_end_irq_o,
  output logic      [2:0]  service_level_o,
  // memory bus
  output logic      [23:0] mem_addr_o,
  output logic             mem_rd_o,
  output logic             mem_wr_o,
  output logic      [1:0]  mem_size_o,
  output logic      [31:0] mem_wdata_o,
  input  wire logic [31:0] mem_rdata_i,
  input  wire logic        mem_ack_i,
  output logic      [2:0]  cycle_state_o
);
  localparam int CW = $clog2(CHANNELS);

  ////////////////////////////////////////////////////////////////////////////////
  // per-channel state
  logic [31:0]         src_reg   [CHANNELS];
  logic [31:0]         dst_reg   [CHANNELS];
  logic [15:0]         cnt_reg   [CHANNELS];
  logic [5:0]          mode_reg  [CHANNELS];
  logic [5:0]          vec_reg   [CHANNELS];
  logic [CHANNELS-1:0] soft_start_request_reg;
  logic [CHANNELS-1:0] burst_select_reg;
  logic [CHANNELS-1:0] burst_active_reg;

  mdma_state_e         state_reg;
  mdma_state_e         state_next;
  logic [CW-1:0]       chan_reg;
  logic                rd_busy_reg;
  logic                wr_busy_reg;

  logic [31:0]         reg_rdata_reg;
  logic [63:0]         irq_clr_reg;
  logic [63:0]         claimed_reg;
  logic [7:0]          end_irq_reg;
  logic [2:0]          level_reg;
  logic [23:0]         mem_addr_reg;
  logic [1:0]          mem_size_reg;
  logic [31:0]         mem_wdata_reg;

  ////////////////////////////////////////////////////////////////////////////////
  // helpers
  function automatic logic [31:0] step_addr(input logic [31:0] a, input logic [1:0] op,
                                            input logic [1:0] sz);
    logic [31:0] n;
    n = 32'h0000_0001 << sz;
    case (op)
      MDMA_STEP_INC: step_addr = a + n;
      MDMA_STEP_DEC: step_addr = a - n;
      default:       step_addr = a;
    endcase
  endfunction

  function automatic logic is_kind(input logic [7:0] addr, input logic [3:0] kind);
    is_kind = (addr[7:4] == kind) && (addr[3] == 1'b0);
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // request gathering and arbitration
  logic [CHANNELS-1:0] hw_req;
  logic [CHANNELS-1:0] all_req;
  logic [CHANNELS-1:0] soft_wr_set;
  wire                 grant_any;
  wire  [CW-1:0]       grant_idx;
  wire                 accept;

  always_comb begin
    for (int i = 0; i < CHANNELS; i++) begin
      hw_req[i] = (vec_reg[i] != `MDMA_VEC_NONE) && irq_pend_i[vec_reg[i]];
    end
  end

  assign soft_wr_set = (reg_wr_i && reg_addr_i == `MDMA_ADDR_SOFT) ?
                       reg_wdata_i[CHANNELS-1:0] : '0;
  assign all_req = hw_req | soft_start_request_reg | (burst_select_reg & burst_active_reg);

  mdma_prio #(
    .N (CHANNELS)
  ) u_prio (
    .req_i (all_req),
    .any_o (grant_any),
    .idx_o (grant_idx)
  );

  assign accept = (state_reg == MDMA_ST_IDLE) && grant_any && !cpu_halt_i &&
                  (cpu_imask_i < `MDMA_LEVEL);

  ////////////////////////////////////////////////////////////////////////////////
  // data fifo between read and write halves
  wire        fifo_in_ready;
  wire        fifo_out_valid;
  wire [31:0] fifo_out_data;
  wire        fifo_push;
  wire        fifo_pop;
  wire        rd_start;
  wire        wr_start;
  wire        rd_done;
  wire        wr_done;

  // read only starts while the fifo has room, so a push is never dropped
  assign rd_start  = (state_reg == MDMA_ST_READ) && !rd_busy_reg && fifo_in_ready;
  assign rd_done   = rd_busy_reg && mem_ack_i;
  assign fifo_push = rd_done;
  assign wr_start  = (state_reg == MDMA_ST_WRITE) && !wr_busy_reg && fifo_out_valid;
  assign fifo_pop  = wr_start;
  assign wr_done   = wr_busy_reg && mem_ack_i;

  mdma_fifo #(
    .WIDTH (32),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .sys_clk_i   (sys_clk_i),
    .rst_i       (rst_i),
    .in_valid_i  (fifo_push),
    .in_ready_o  (fifo_in_ready),
    .in_data_i   (mem_rdata_i),
    .out_valid_o (fifo_out_valid),
    .out_ready_i (fifo_pop),
    .out_data_o  (fifo_out_data)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // service sequencer
  wire [1:0]  cur_size = mode_reg[chan_reg][`MDMA_MODE_SIZE_LSB +: 2];
  wire [1:0]  cur_sop  = mode_reg[chan_reg][`MDMA_MODE_SRC_LSB +: 2];
  wire [1:0]  cur_dop  = mode_reg[chan_reg][`MDMA_MODE_DST_LSB +: 2];
  wire [15:0] cnt_dec  = cnt_reg[chan_reg] - 16'h0001;
  wire        cnt_zero = (cnt_dec == 16'h0000);

  always_comb begin
    state_next = state_reg;
    case (state_reg)
      MDMA_ST_IDLE:  if (accept) state_next = MDMA_ST_PF1;
      MDMA_ST_PF1:   state_next = MDMA_ST_PF2;
      MDMA_ST_PF2:   state_next = MDMA_ST_READ;
      MDMA_ST_READ:  if (rd_done) state_next = MDMA_ST_WRITE;
      MDMA_ST_WRITE: if (wr_done) state_next = MDMA_ST_PF5;
      MDMA_ST_PF5:   state_next = MDMA_ST_IDLE;
      default:       state_next = MDMA_ST_IDLE;
    endcase
  end

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      state_reg   <= MDMA_ST_IDLE;
      chan_reg    <= '0;
      rd_busy_reg <= 1'b0;
      wr_busy_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      if (accept) begin
        chan_reg <= grant_idx;
      end
      rd_busy_reg <= rd_start | (rd_busy_reg & ~mem_ack_i);
      wr_busy_reg <= wr_start | (wr_busy_reg & ~mem_ack_i);
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // bus outputs
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      mem_addr_reg  <= '0;
      mem_size_reg  <= '0;
      mem_wdata_reg <= '0;
    end else begin
      if (rd_start) begin
        mem_addr_reg <= src_reg[chan_reg][`MDMA_ADDR_BITS-1:0];
        mem_size_reg <= cur_size;
      end else if (wr_start) begin
        mem_addr_reg  <= dst_reg[chan_reg][`MDMA_ADDR_BITS-1:0];
        mem_wdata_reg <= fifo_out_data;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // channel registers, cpu writes and service updates
  wire       wr_kind_src  = reg_wr_i && is_kind(reg_addr_i, `MDMA_KIND_SRC);
  wire       wr_kind_dst  = reg_wr_i && is_kind(reg_addr_i, `MDMA_KIND_DST);
  wire       wr_kind_cnt  = reg_wr_i && is_kind(reg_addr_i, `MDMA_KIND_CNT);
  wire       wr_kind_mode = reg_wr_i && is_kind(reg_addr_i, `MDMA_KIND_MODE);
  wire       wr_kind_vec  = reg_wr_i && is_kind(reg_addr_i, `MDMA_KIND_VEC);
  wire [2:0] wr_ch        = reg_addr_i[2:0];

  // loaded over the control register port
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      for (int i = 0; i < CHANNELS; i++) begin
        src_reg[i]  <= '0;
        dst_reg[i]  <= '0;
        cnt_reg[i]  <= '0;
        mode_reg[i] <= '0;
        vec_reg[i]  <= `MDMA_VEC_RST;
      end
    end else begin
      if (wr_done) begin
        src_reg[chan_reg] <= step_addr(src_reg[chan_reg], cur_sop, cur_size);
        dst_reg[chan_reg] <= step_addr(dst_reg[chan_reg], cur_dop, cur_size);
        cnt_reg[chan_reg] <= cnt_dec;
        if (cnt_zero) begin
          vec_reg[chan_reg] <= `MDMA_VEC_NONE;
        end
      end
      // a reload in the finishing cycle wins so software can rearm at once
      if (wr_kind_src) src_reg[wr_ch] <= reg_wdata_i;
      if (wr_kind_dst) dst_reg[wr_ch] <= reg_wdata_i;
      if (wr_kind_cnt) cnt_reg[wr_ch] <= reg_wdata_i[15:0];
      if (wr_kind_mode) mode_reg[wr_ch] <= reg_wdata_i[5:0];
      if (wr_kind_vec) vec_reg[wr_ch] <= reg_wdata_i[5:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // soft start, burst and end-of-transfer
  logic [CHANNELS-1:0] done_mask;
  logic [CHANNELS-1:0] end_mask;

  assign done_mask = wr_done ? (CHANNELS'(1) << chan_reg) : '0;
  assign end_mask  = (wr_done && cnt_zero) ? (CHANNELS'(1) << chan_reg) : '0;

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      soft_start_request_reg <= `MDMA_SOFT_RST;
      burst_select_reg       <= `MDMA_BURST_RST;
      burst_active_reg       <= '0;
      end_irq_reg            <= '0;
    end else begin
      soft_start_request_reg <= (soft_start_request_reg & ~done_mask) | soft_wr_set;
      if (reg_wr_i && reg_addr_i == `MDMA_ADDR_BURST) begin
        burst_select_reg <= reg_wdata_i[CHANNELS-1:0];
      end
      burst_active_reg <= (burst_active_reg | (done_mask & burst_select_reg)) & ~end_mask;
      end_irq_reg <= end_mask;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // interrupt controller handshake
  logic [63:0] claim_next;

  always_comb begin
    claim_next = '0;
    for (int i = 0; i < CHANNELS; i++) begin
      if (vec_reg[i] != `MDMA_VEC_NONE) begin
        claim_next[vec_reg[i]] = 1'b1;
      end
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      irq_clr_reg <= '0;
      claimed_reg <= '0;
      level_reg   <= '0;
    end else begin
      irq_clr_reg <= '0;
      if (accept && hw_req[grant_idx]) begin
        irq_clr_reg[vec_reg[grant_idx]] <= 1'b1;
      end
      claimed_reg <= claim_next;
      level_reg <= (state_next != MDMA_ST_IDLE) ? `MDMA_LEVEL : 3'h0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // register readback
  logic [31:0] rd_mux;
  wire  [2:0]  rd_ch = reg_addr_i[2:0];

  always_comb begin
    rd_mux = 32'h0000_0000;
    if (reg_addr_i == `MDMA_ADDR_SOFT) begin
      rd_mux[CHANNELS-1:0] = soft_start_request_reg;
    end else if (reg_addr_i == `MDMA_ADDR_BURST) begin
      rd_mux[CHANNELS-1:0] = burst_select_reg;
    end else if (is_kind(reg_addr_i, `MDMA_KIND_SRC)) begin
      rd_mux = src_reg[rd_ch];
    end else if (is_kind(reg_addr_i, `MDMA_KIND_DST)) begin
      rd_mux = dst_reg[rd_ch];
    end else if (is_kind(reg_addr_i, `MDMA_KIND_CNT)) begin
      rd_mux[15:0] = cnt_reg[rd_ch];
    end else if (is_kind(reg_addr_i, `MDMA_KIND_MODE)) begin
      rd_mux[5:0] = mode_reg[rd_ch];
    end else if (is_kind(reg_addr_i, `MDMA_KIND_VEC)) begin
      rd_mux[5:0] = vec_reg[rd_ch];
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      reg_rdata_reg <= '0;
    end else begin
      reg_rdata_reg <= rd_mux;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // outputs, all from flops
  logic [2:0] cycle_reg;

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      cycle_reg <= '0;
    end else begin
      case (state_next)
        MDMA_ST_PF1:   cycle_reg <= 3'h1;
        MDMA_ST_PF2:   cycle_reg <= 3'h2;
        MDMA_ST_READ:  cycle_reg <= 3'h3;
        MDMA_ST_WRITE: cycle_reg <= 3'h4;
        MDMA_ST_PF5:   cycle_reg <= 3'h5;
        default:       cycle_reg <= 3'h0;
      endcase
    end
  end

  assign reg_rdata_o        = reg_rdata_reg;
  assign irq_clr_o          = irq_clr_reg;
  assign src_claimed_o      = claimed_reg;
  assign transfer_end_irq_o = end_irq_reg;
  assign service_level_o    = level_reg;
  assign mem_addr_o         = mem_addr_reg;
  assign mem_rd_o           = rd_busy_reg;
  assign mem_wr_o           = wr_busy_reg;
  assign mem_size_o         = mem_size_reg;
  assign mem_wdata_o        = mem_wdata_reg;
  assign cycle_state_o      = cycle_reg;
endmodule
`default_nettype wire

// ===== mdma_mem.sv
// memory bus partner model for the micro dma engine
// assumes one clock; answers each request after 0 to 3 wait cycles
`default_nettype none
module mdma_mem (
  input  wire logic        sys_clk_i,
  input  wire logic        rst_i,
  input  wire logic        mem_rd_i,
  input  wire logic        mem_wr_i,
  input  wire logic [23:0] mem_addr_i,
  output logic             mem_ack_o,
  output logic      [31:0] mem_rdata_o
);
  int wait_cnt;
  // rdata toggles in idle and post-ack cycles, holding through wait cycles, so stale data never passes as good
  always @(posedge sys_clk_i) begin
    if (rst_i) begin
      mem_ack_o   <= 1'b0;
      mem_rdata_o <= 32'h0;
      wait_cnt    <= 0;
    end else if (mem_ack_o || !(mem_rd_i || mem_wr_i)) begin
      mem_ack_o   <= 1'b0;
      mem_rdata_o <= ~mem_rdata_o;
      wait_cnt    <= $urandom % 4;
    end else if (wait_cnt == 0) begin
      mem_ack_o   <= 1'b1;
      mem_rdata_o <= {~mem_addr_i[7:0], mem_addr_i};
    end else begin
      wait_cnt <= wait_cnt - 1;
    end
  end
endmodule
`default_nettype wire

// ===== mdma_top_assertions.sv
// port checker for the micro dma engine
// assumes it is bound into every mdma_top instance
`default_nettype none
module mdma_chk (
  input  wire logic        sys_clk_i,
  input  wire logic        rst_i,
  input  wire logic [2:0]  cpu_imask_i,
  input  wire logic        cpu_halt_i,
  input  wire logic [63:0] irq_clr_o,
  input  wire logic [63:0] src_claimed_o,
  input  wire logic [7:0]  transfer_end_irq_o,
  input  wire logic [2:0]  service_level_o,
  input  wire logic [23:0] mem_addr_o,
  input  wire logic        mem_rd_o,
  input  wire logic        mem_wr_o,
  input  wire logic        mem_ack_i,
  input  wire logic [2:0]  cycle_state_o
);
  default clocking cb @(posedge sys_clk_i);
  endclocking
  default disable iff (rst_i);
  wire idle = cycle_state_o == 3'h0;
  a_level_six: assert property (
    !idle |-> service_level_o == 3'h6) else $error("service level wrong");
  a_mask_blocks: assert property (
    idle && cpu_imask_i >= 3'h6 |=> idle) else $error("service under high mask");
  a_halt_blocks: assert property (
    idle && cpu_halt_i |=> idle) else $error("service during halt");
  a_clr_on_accept: assert property (
    |irq_clr_o |-> cycle_state_o == 3'h1 && $onehot(irq_clr_o)
      && (irq_clr_o & src_claimed_o) == irq_clr_o) else $error("bad latch clear");
  a_read_held: assert property (
    mem_rd_o && !mem_ack_i |=> mem_rd_o && $stable(mem_addr_o)) else $error("read dropped");
  a_end_in_five: assert property (
    |transfer_end_irq_o |-> cycle_state_o == 3'h5 && $onehot(transfer_end_irq_o))
    else $error("end pulse misplaced");
  a_state_order: assert property (
    cycle_state_o == 3'h1 |=> cycle_state_o == 3'h2 ##1 cycle_state_o == 3'h3)
    else $error("prefetch order wrong");
  a_bus_by_state: assert property (
    (mem_rd_o |-> cycle_state_o == 3'h3) and (mem_wr_o |-> cycle_state_o == 3'h4))
    else $error("bus access in wrong state");
  a_read_to_write: assert property (
    $rose(cycle_state_o == 3'h3) |-> ##[1:40] cycle_state_o == 3'h4)
    else $error("write state late");
  a_five_then_idle: assert property (
    cycle_state_o == 3'h5 |=> idle) else $error("no idle after service");
  c_end_seen: cover property (|transfer_end_irq_o);
  c_clr_seen: cover property (|irq_clr_o);
  c_slow_read: cover property (mem_rd_o && !mem_ack_i ##1 mem_ack_i);
endmodule
bind mdma_top mdma_chk i_mdma_chk (.*);
`default_nettype wire

// ===== interrupt_driven_micro_dma_test.sv
// self-checking bench for the micro dma engine
// assumes mdma_mem answers the bus and the bench acts as interrupt controller
`default_nettype none
module interrupt_driven_micro_dma_test;
  timeunit 1ns;
  timeprecision 100ps;
  import mdma_pkg::*;
  logic        sys_clk_i = 1'b0, rst_i = 1'b1, reg_wr_i = 1'b0, cpu_halt_i = 1'b0;
  logic        mem_ack_i, mem_rd_o, mem_wr_o;
  logic [7:0]  reg_addr_i = 8'h00, transfer_end_irq_o, end_exp = 8'h00;
  logic [31:0] reg_wdata_i = 32'h0, reg_rdata_o, mem_rdata_i, mem_wdata_o;
  logic [63:0] irq_pend_i = 64'h0, irq_clr_o, src_claimed_o, clr_seen = 64'h0;
  logic [2:0]  cpu_imask_i = 3'h0, service_level_o, cycle_state_o;
  logic [23:0] mem_addr_o;
  logic [1:0]  mem_size_o;
  logic [31:0] m_src[8], m_dst[8];
  logic [5:0]  m_mode[8];
  int          m_cnt[8], q[$], n_errors = 0, cmp_count = 0, cyc = 0, c, n, v, k;
  mdma_top i_mdma_top (.*);
  mdma_mem i_mdma_mem (.sys_clk_i, .rst_i, .mem_rd_i(mem_rd_o), .mem_wr_i(mem_wr_o),
    .mem_addr_i(mem_addr_o), .mem_ack_o(mem_ack_i), .mem_rdata_o(mem_rdata_i));
  always #2 sys_clk_i = ~sys_clk_i;
  ////////////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] msk(logic [1:0] z);
    return z == 2'h0 ? 32'hFF : z == 2'h1 ? 32'hFFFF : 32'hFFFFFFFF;
  endfunction
  function automatic logic [31:0] stp(logic [31:0] a, logic [1:0] s, logic [1:0] z);
    return s == 2'h1 ? a + (32'h1 << z) : s == 2'h2 ? a - (32'h1 << z) : a;
  endfunction
  // wide enough for the 64-bit source vectors, so high sources cannot slip through
  task automatic chk(logic [63:0] got, logic [63:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_errors++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wrap_up();
    $display("errors=%0d compares=%0d", n_errors, cmp_count);
    if (n_errors == 0 && cmp_count > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic wr(logic [7:0] a, logic [31:0] d);
    @(posedge sys_clk_i);
    reg_wr_i    <= 1'b1;
    reg_addr_i  <= a;
    reg_wdata_i <= d;
    @(posedge sys_clk_i);
    reg_wr_i <= 1'b0;
  endtask
  task automatic rd(logic [7:0] a, logic [31:0] e);
    @(posedge sys_clk_i);
    reg_addr_i <= a;
    @(posedge sys_clk_i);
    #1 chk(reg_rdata_o, e);
  endtask
  task automatic cfg(int ch, logic [31:0] s, d, int cnt, logic [5:0] m, vec);
    wr(8'(8'h10 + ch), s);
    wr(8'(8'h20 + ch), d);
    wr(8'(8'h30 + ch), cnt);
    wr(8'(8'h40 + ch), m);
    wr(8'(8'h50 + ch), vec);
    m_src[ch]  = s;
    m_dst[ch]  = d;
    m_cnt[ch]  = cnt;
    m_mode[ch] = m;
  endtask
  task automatic wait_idle();
    repeat (300) begin
      @(posedge sys_clk_i);
      if (q.size() == 0 && cycle_state_o === 3'h0) break;
    end
    chk(q.size(), 0);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  // reference model of the channel state, updated at each write ack
  // latch set by an edge, cleared by engine
  always @(posedge sys_clk_i) begin
    if (|irq_clr_o) irq_pend_i <= irq_pend_i & ~irq_clr_o;
    clr_seen |= irq_clr_o;
    if (!rst_i) chk(transfer_end_irq_o, end_exp);
    end_exp = 8'h00;
    if (q.size() > 0 && mem_ack_i === 1'b1) begin
      k = q[0];
      if (mem_rd_o) chk(mem_addr_o, m_src[k][23:0]);
      if (mem_wr_o) begin
        chk(mem_addr_o, m_dst[k][23:0]);
        chk(mem_wdata_o & msk(m_mode[k][1:0]), {~m_src[k][7:0], m_src[k][23:0]}
          & msk(m_mode[k][1:0]));
        chk(mem_size_o, m_mode[k][1:0]);
        m_src[k] = stp(m_src[k], m_mode[k][3:2], m_mode[k][1:0]);
        m_dst[k] = stp(m_dst[k], m_mode[k][5:4], m_mode[k][1:0]);
        m_cnt[k] = (m_cnt[k] - 1) & 32'hFFFF;
        if (m_cnt[k] == 0) end_exp = 8'h1 << k;
        void'(q.pop_front());
      end
    end
  end
  always @(posedge sys_clk_i) if (++cyc > 20000) begin
    n_errors++;
    wrap_up();
  end
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    void'($urandom(32'h96102F9B));
    repeat (12) @(posedge sys_clk_i);
    rst_i <= 1'b0;
    rd(8'h00, 32'h0);
    rd(8'h01, 32'h0);
    wr(8'h08, 32'hFF);
    rd(8'h08, 32'h0);
    wr(8'h33, 32'hFFFF1234);
    rd(8'h33, 32'h1234);
    for (int i = 0; i < 6; i++) begin
      c = $urandom % 8;
      n = 1 + $urandom % 2;
      cfg(c, $urandom, $urandom, n, {2'($urandom % 3), 2'($urandom % 3), 2'(i % 3)}, 6'h0);
      repeat (n) begin
        q.push_back(c);
        wr(8'h00, 32'h1 << c);
        wait_idle();
      end
      rd(8'h00, 32'h0);
    end
    v = 1 + $urandom % 63;
    cfg(4, $urandom, $urandom, 2, 6'h15, 6'(v));
    // claimed flag is registered one edge after the vector write
    @(posedge sys_clk_i);
    #1 chk(src_claimed_o[v], 1'b1);
    clr_seen = 64'h0;
    repeat (2) begin
      q.push_back(4);
      @(posedge sys_clk_i);
      irq_pend_i[v] <= 1'b1;
      wait_idle();
      chk(clr_seen, 64'h1 << v);
      clr_seen = 64'h0;
    end
    chk(src_claimed_o[v], 1'b0);
    rd(8'h54, 32'h0);
    @(posedge sys_clk_i);
    irq_pend_i[v] <= 1'b1;
    repeat (20) @(posedge sys_clk_i);
    chk(cycle_state_o, 3'h0);
    irq_pend_i[v] <= 1'b0;
    cfg(5, $urandom, $urandom, 1, 6'h26, 6'(v));
    cfg(2, $urandom, $urandom, 1, 6'h19, 6'h0);
    cpu_halt_i <= 1'b1;
    irq_pend_i[v] <= 1'b1;
    wr(8'h00, 32'h04);
    repeat (20) @(posedge sys_clk_i);
    chk(cycle_state_o, 3'h0);
    q.push_back(2);
    q.push_back(5);
    cpu_halt_i <= 1'b0;
    wait_idle();
    cfg(3, $urandom, $urandom, 1, 6'h2A, 6'h0);
    cpu_imask_i <= 3'h6;
    q.push_back(3);
    wr(8'h00, 32'h08);
    repeat (20) @(posedge sys_clk_i);
    chk(cycle_state_o, 3'h0);
    cpu_imask_i <= 3'($urandom % 6);
    wait_idle();
    cfg(6, $urandom, $urandom, 3, 6'h16, 6'h0);
    wr(8'h01, 32'h40);
    repeat (3) q.push_back(6);
    wr(8'h00, 32'h40);
    wait_idle();
    wr(8'h01, 32'h0);
    wrap_up();
  end
endmodule
`default_nettype wire
